/* verilog/pmbus_sel_pkg.sv */
// constants and carrier types for the dual-master command selector
package pmbus_sel_pkg;

  // command codes
  localparam logic [7:0] CMD_NONE         = 8'h00;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_READ_INPUT   = 8'hd4;
  localparam logic [7:0] CMD_FW_REV       = 8'hd5;
  localparam logic [7:0] CMD_RUN_TIMER    = 8'hd6;
  localparam logic [7:0] CMD_BUS_STATUS   = 8'hd7;
  localparam logic [7:0] CMD_TAKE_OVER    = 8'hd8;
  localparam logic [7:0] CMD_NVM_LOW      = 8'hd9;
  localparam logic [7:0] CMD_NVM_HIGH     = 8'hf4;

  // byte counts returned ahead of each block read
  localparam logic [5:0] INPUT_COUNT = 6'h04;
  localparam logic [5:0] FW_COUNT    = 6'h06;
  localparam logic [5:0] TIMER_COUNT = 6'h03;
  localparam logic [5:0] NVM_COUNT   = 6'h20;
  localparam int         NVM_BYTES   = 64;
  localparam logic [5:0] NVM_HIGH_BASE = 6'h20;

  // bus ownership status byte: per-bus nibble, bus 1 in the upper nibble
  localparam int         ST_OWN       = 0;
  localparam int         ST_REQ       = 1;
  localparam int         ST_ALERT     = 2;
  localparam int         ST_ERR       = 3;
  localparam int         ST_BUS1_BASE = 4;
  localparam logic       OWNER_RESET  = 1'b0;

  // run-hour timer: 20 MHz clock, one hour per tick
  localparam longint unsigned CLK_HZ           = 64'd20000000;
  localparam longint unsigned SECONDS_PER_HOUR = 64'd3600;
  localparam longint unsigned HOUR_CYCLES      = CLK_HZ * SECONDS_PER_HOUR;
  // ten years is about 87600 hours, 17 bits; 24 bits matches the 3-byte reply
  localparam int              RUN_HOURS_W      = 24;

  typedef enum logic [1:0] {BYTE_ADDR, BYTE_CMD, BYTE_DATA} byte_kind_t;

  // byte-level events from one bus front end
  typedef struct packed {
    logic       wr_stb;
    byte_kind_t kind;
    logic [7:0] wr_data;
    logic       rd_stb;
    logic       stop;
  } bus_req_t;

  // answers to one bus front end
  typedef struct packed {
    logic [7:0] rd_data;
    logic       stretch;
    logic       alert;
  } bus_rsp_t;

endpackage : pmbus_sel_pkg

/* verilog/dual_master_pmbus_control_selector.sv */
// command interpreter and control selector for two pmbus host buses
//
// Summary of operation
// - input-string read returns input voltage and input power.
// - firmware read returns six revision bytes: primary, secondary, bus controller.
// - run-timer read returns accumulated operating hours.
// - hour accumulator runs whenever the unit is powered, standby or delivering.
// - accumulator is wide enough for about ten years.
// - bus status byte readable from either master at any time.
// - device stretches the clock for one cycle on each read byte fetch; writes are never stretched.
// - status byte holds per-bus error, alert, request, control; reset 0x01.
// - master without control may only take over, clear faults or read the bus status byte.
// - take-over moves control to the requesting master.
// - handover waits until the controlling master's write ends with stop.
// - handover proceeds at once while the owner only reads.
// - reads on both buses are served concurrently.
// - take-over acts only after its trailing PEC checks good.
// - after handover both alert lines assert.
// - clear-faults on a bus releases that bus's alert.
// - only the controlling master's clear-faults clears rectifier status.
// - 64 bytes customer storage, lower half and upper half codes.
// - storage read returns count up to 32, data, then PEC.
`timescale 1ns/1ps
module dual_master_pmbus_control_selector #(
  parameter longint unsigned HOUR_CYCLES = pmbus_sel_pkg::HOUR_CYCLES,
  parameter int              RUN_HOURS_W = pmbus_sel_pkg::RUN_HOURS_W
) (
  input  wire logic                    mclk_i,
  input  wire logic                    rst_n_i,
  input  pmbus_sel_pkg::bus_req_t      bus_i [2],
  output pmbus_sel_pkg::bus_rsp_t      bus_o [2],
  input  wire logic [15:0]             vin_i,
  input  wire logic [15:0]             pin_i,
  input  wire logic [47:0]             fw_rev_i,
  input  wire logic                    fault_alert_i,
  output logic                         fault_clear_o,
  output logic [7:0]                   bus_ownership_status_o
);

  localparam int DIV_W = $clog2(HOUR_CYCLES + 64'd1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HOUR_CYCLES - 64'd1);
  logic                   owner;
  logic [1:0]             requested;
  logic [1:0]             alert;
  logic [1:0]             err;
  logic [1:0]             wr_txn;
  logic [7:0]             cmd     [2];
  logic [5:0]             wcnt    [2];
  logic [5:0]             rcnt    [2];
  logic [7:0]             crc     [2];
  logic [7:0]             rd_data [2];
  logic [7:0]             next_rd [2];
  logic [1:0]             take_req;
  logic [1:0]             clr;
  logic [1:0]             bad;
  logic                   handover;
  logic [DIV_W-1:0]       hour_div;
  logic [RUN_HOURS_W-1:0] hours;
  logic [7:0]             nvm [pmbus_sel_pkg::NVM_BYTES];
  logic [7:0]             status;

  // smbus pec, crc-8 with polynomial x^8+x^2+x+1
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    repeat (8) r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
    return r;
  endfunction : crc8
  // commands a master without control may still issue
  function automatic logic allowed_any(input logic [7:0] c);
    return (c == pmbus_sel_pkg::CMD_TAKE_OVER) || (c == pmbus_sel_pkg::CMD_CLEAR_FAULTS) ||
           (c == pmbus_sel_pkg::CMD_BUS_STATUS);
  endfunction : allowed_any
  function automatic logic [5:0] resp_len(input logic [7:0] c);
    case (c)
      pmbus_sel_pkg::CMD_READ_INPUT: return pmbus_sel_pkg::INPUT_COUNT;
      pmbus_sel_pkg::CMD_FW_REV:     return pmbus_sel_pkg::FW_COUNT;
      pmbus_sel_pkg::CMD_RUN_TIMER:  return pmbus_sel_pkg::TIMER_COUNT;
      pmbus_sel_pkg::CMD_NVM_LOW:    return pmbus_sel_pkg::NVM_COUNT;
      pmbus_sel_pkg::CMD_NVM_HIGH:   return pmbus_sel_pkg::NVM_COUNT;
      default:                       return 6'h00;
    endcase
  endfunction : resp_len
  // payload byte idx of a block read, lowest byte first
  function automatic logic [7:0] payload(input logic [7:0] c, input logic [5:0] idx);
    case (c)
      // voltage lsb, msb, then power lsb, msb
      pmbus_sel_pkg::CMD_READ_INPUT: return 8'({pin_i, vin_i} >> {idx, 3'b000});
      // primary, secondary, bus controller; major before minor
      pmbus_sel_pkg::CMD_FW_REV:     return 8'(fw_rev_i >> {idx, 3'b000});
      pmbus_sel_pkg::CMD_RUN_TIMER:  return 8'(hours >> {idx, 3'b000});
      pmbus_sel_pkg::CMD_NVM_LOW:    return nvm[idx];
      pmbus_sel_pkg::CMD_NVM_HIGH:   return nvm[idx | pmbus_sel_pkg::NVM_HIGH_BASE];
      default:                       return 8'h00;
    endcase
  endfunction : payload
  always_comb begin
    status = 8'h00;
    status[pmbus_sel_pkg::ST_OWN]   = (owner == 1'b0);
    status[pmbus_sel_pkg::ST_REQ]   = requested[0];
    status[pmbus_sel_pkg::ST_ALERT] = alert[0];
    status[pmbus_sel_pkg::ST_ERR]   = err[0];
    status[pmbus_sel_pkg::ST_BUS1_BASE + pmbus_sel_pkg::ST_OWN]   = (owner == 1'b1);
    status[pmbus_sel_pkg::ST_BUS1_BASE + pmbus_sel_pkg::ST_REQ]   = requested[1];
    status[pmbus_sel_pkg::ST_BUS1_BASE + pmbus_sel_pkg::ST_ALERT] = alert[1];
    status[pmbus_sel_pkg::ST_BUS1_BASE + pmbus_sel_pkg::ST_ERR]   = err[1];
  end

  // each bus has its own read path, so both serve reads in the same cycle
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      // past the last data byte the running pec is returned
      next_rd[b] = crc[b];
      if (cmd[b] == pmbus_sel_pkg::CMD_BUS_STATUS) begin
        // single status byte, then pec if the host keeps reading
        if (rcnt[b] == 6'h00) begin
          next_rd[b] = status;
        end
      end else if (rcnt[b] == 6'h00) begin
        next_rd[b] = {2'b00, resp_len(cmd[b])};
      end else if (rcnt[b] <= resp_len(cmd[b])) begin
        next_rd[b] = payload(cmd[b], rcnt[b] - 6'h01);
      end
    end
  end

  // stop-time decode of each bus's finished write
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      // address, command and pec folded in must leave a zero remainder
      take_req[b] = bus_i[b].stop && wr_txn[b] && (cmd[b] == pmbus_sel_pkg::CMD_TAKE_OVER) &&
                    (wcnt[b] == 6'h02) && (crc[b] == 8'h00);
      clr[b]      = bus_i[b].stop && wr_txn[b] &&
                    (cmd[b] == pmbus_sel_pkg::CMD_CLEAR_FAULTS) &&
                    ((wcnt[b] == 6'h01) || ((wcnt[b] == 6'h02) && (crc[b] == 8'h00)));
      // a command byte a non-owner may not send
      bad[b]      = bus_i[b].wr_stb && (bus_i[b].kind == pmbus_sel_pkg::BYTE_CMD) &&
                    (owner != 1'(b)) && !allowed_any(bus_i[b].wr_data);
    end
  end

  // the owner's open write blocks the handover until its stop clears wr_txn
  // a read clears wr_txn at the repeated start, so it never blocks
  assign handover = requested[~owner] && !wr_txn[owner];
  // per-bus transaction tracking; the front end never overlaps strobes
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_txn <= 2'b00;
      for (int b = 0; b < 2; b++) begin
        cmd[b]     <= pmbus_sel_pkg::CMD_NONE;
        wcnt[b]    <= 6'h00;
        rcnt[b]    <= 6'h00;
        crc[b]     <= 8'h00;
        rd_data[b] <= 8'h00;
      end
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (bus_i[b].wr_stb) begin
          case (bus_i[b].kind)
            pmbus_sel_pkg::BYTE_ADDR: begin
              if (!bus_i[b].wr_data[0]) begin
                crc[b]    <= crc8(8'h00, bus_i[b].wr_data);
                wr_txn[b] <= 1'b1;
                wcnt[b]   <= 6'h00;
              end else begin
                crc[b]    <= crc8(crc[b], bus_i[b].wr_data);
                wr_txn[b] <= 1'b0;
                rcnt[b]   <= 6'h00;
              end
            end
            pmbus_sel_pkg::BYTE_CMD: begin
              crc[b]  <= crc8(crc[b], bus_i[b].wr_data);
              wcnt[b] <= 6'h01;
              // a forbidden command is parked as no command and does nothing
              cmd[b]  <= bad[b] ? pmbus_sel_pkg::CMD_NONE : bus_i[b].wr_data;
            end
            default: begin
              crc[b] <= crc8(crc[b], bus_i[b].wr_data);
              if (wcnt[b] != 6'h3f) begin
                wcnt[b] <= wcnt[b] + 6'h01;
              end
            end
          endcase
        end
        if (bus_i[b].rd_stb) begin
          rd_data[b] <= next_rd[b];
          crc[b]     <= crc8(crc[b], next_rd[b]);
          if (rcnt[b] != 6'h3f) begin
            rcnt[b] <= rcnt[b] + 6'h01;
          end
        end
        if (bus_i[b].stop) begin
          wr_txn[b] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      owner     <= pmbus_sel_pkg::OWNER_RESET;
      requested <= 2'b00;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (take_req[b] && (owner != 1'(b))) begin
          requested[b] <= 1'b1;
        end
      end
      if (handover) begin
        owner            <= ~owner;
        requested[~owner] <= 1'b0;
      end
    end
  end

  // alert per bus; set wins over a clear in the same cycle
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alert <= 2'b00;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (handover || fault_alert_i) begin
          alert[b] <= 1'b1;
        end else if (clr[b]) begin
          // each master releases only its own bus's alert
          alert[b] <= 1'b0;
        end
      end
    end
  end
  // command error flag, cleared by that bus's clear-faults; set wins
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err <= 2'b00;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (bad[b]) begin
          err[b] <= 1'b1;
        end else if (clr[b]) begin
          err[b] <= 1'b0;
        end
      end
    end
  end
  // rectifier status is cleared only by the owner's clear-faults
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_clear_o <= 1'b0;
    end else begin
      fault_clear_o <= clr[owner];
    end
  end
  // the hour timer runs from power-up in every operating state
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hour_div <= '0;
      hours    <= '0;
    end else if (hour_div == DIV_LAST) begin
      hour_div <= '0;
      // 24 bits hold far more than ten years of hours
      hours    <= hours + RUN_HOURS_W'(1);
    end else begin
      hour_div <= hour_div + DIV_W'(1);
    end
  end
  // customer storage; only the owner reaches here since others park the command
  // count byte is skipped, data bytes land first to last; bytes past 32 are dropped
  // storage has no reset: it models nonvolatile contents
  always_ff @(posedge mclk_i) begin
    for (int b = 0; b < 2; b++) begin
      if (bus_i[b].wr_stb && (bus_i[b].kind == pmbus_sel_pkg::BYTE_DATA) && wr_txn[b] &&
          (wcnt[b] >= 6'h02) && (wcnt[b] <= 6'h21)) begin
        if (cmd[b] == pmbus_sel_pkg::CMD_NVM_LOW) begin
          nvm[wcnt[b] - 6'h02] <= bus_i[b].wr_data;
        end else if (cmd[b] == pmbus_sel_pkg::CMD_NVM_HIGH) begin
          nvm[(wcnt[b] - 6'h02) | pmbus_sel_pkg::NVM_HIGH_BASE] <= bus_i[b].wr_data;
        end
      end
    end
  end
  // clock held for the one cycle the read byte takes to fetch
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      bus_o[b].rd_data = rd_data[b];
      bus_o[b].stretch = bus_i[b].rd_stb;
      bus_o[b].alert   = alert[b];
    end
  end
  assign bus_ownership_status_o = status;
  chk_handover_alert: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    handover |=> (alert == 2'b11)) else $error("alerts not raised after handover");
  chk_owner_moves: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !$stable(owner) |-> $past(requested[1]) != $past(requested[0]))
    else $error("owner changed without a single pending request");
  chk_idle_handover: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (wr_txn[owner] && !bus_i[owner].stop) |=> $stable(owner))
    else $error("control moved during owner write");
  chk_pec_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (bus_i[1].stop && wr_txn[1] && cmd[1] == pmbus_sel_pkg::CMD_TAKE_OVER && crc[1] != 8'h00
     && owner == 1'b0 && !requested[1]) |=> !requested[1])
    else $error("take-over accepted with bad pec");
  chk_error_flag: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    bad[1] |=> (err[1] && cmd[1] == pmbus_sel_pkg::CMD_NONE))
    else $error("forbidden command not flagged");
  chk_alert_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (clr == 2'b10 && !handover && !fault_alert_i) |=> (!alert[1] && $stable(alert[0])))
    else $error("clear-faults did not release own alert only");
  chk_owner_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (clr[0] && !clr[1] && owner == 1'b1) |=> !fault_clear_o)
    else $error("non-owner cleared rectifier status");
  chk_status_read: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (bus_i[0].rd_stb && cmd[0] == pmbus_sel_pkg::CMD_BUS_STATUS && rcnt[0] == 6'h00)
    |=> bus_o[0].rd_data == $past(status)) else $error("status byte wrong");
  chk_pec_tail: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (bus_i[0].rd_stb && cmd[0] == pmbus_sel_pkg::CMD_FW_REV && rcnt[0] == 6'h07)
    |=> bus_o[0].rd_data == $past(crc[0])) else $error("pec not after firmware bytes");
  chk_hour_tick: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (hour_div == DIV_LAST) |=> (hours == $past(hours) + RUN_HOURS_W'(1) && hour_div == '0))
    else $error("hour timer did not advance");
endmodule : dual_master_pmbus_control_selector

/* verif/host_pair_model.sv */
// host masters for both buses: byte events, read fetches and a running check byte
`timescale 1ns/1ps
module host_pair_model (
  input  wire logic               mclk_i,
  output pmbus_sel_pkg::bus_req_t req_o [2],
  input  pmbus_sel_pkg::bus_rsp_t rsp_i [2]
);
  logic [7:0] crc [2];

  // both buses idle from time zero
  initial begin
    req_o[0] = '0;
    req_o[1] = '0;
  end

  // crc-8, polynomial 0x07, one byte at a time
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    repeat (8) x = x[7] ? ((x << 1) ^ 8'h07) : (x << 1);
    return x;
  endfunction : crc8

  // whole byte per event, one idle cycle between events
  task automatic put(input int b, input pmbus_sel_pkg::byte_kind_t k, input logic [7:0] d);
    @(posedge mclk_i);
    #1;
    if (k == pmbus_sel_pkg::BYTE_ADDR && !d[0]) crc[b] = 8'h00;
    crc[b] = crc8(crc[b], d);
    req_o[b].kind = k;
    req_o[b].wr_data = d;
    req_o[b].wr_stb = 1'b1;
    @(posedge mclk_i);
    #1;
    req_o[b].wr_stb = 1'b0;
    req_o[b].wr_data = ~d; // released data never shows the stale byte
  endtask : put

  // fetch one read byte, answer taken after the strobe edge
  task automatic get(input int b, output logic [7:0] d);
    @(posedge mclk_i);
    #1;
    req_o[b].rd_stb = 1'b1;
    @(posedge mclk_i);
    #1;
    req_o[b].rd_stb = 1'b0;
    d = rsp_i[b].rd_data;
    crc[b] = crc8(crc[b], d);
  endtask : get

  // every transfer closes with a stop
  task automatic fin(input int b);
    @(posedge mclk_i);
    #1;
    req_o[b].stop = 1'b1;
    @(posedge mclk_i);
    #1;
    req_o[b].stop = 1'b0;
  endtask : fin
endmodule : host_pair_model

/* verif/test_dual_master_pmbus_control_selector.sv */
// self-checking bench for the dual-master command selector
`timescale 1ns/1ps
module test_dual_master_pmbus_control_selector;
  localparam logic [7:0] DEV_W = 8'hb0; // arbitrary bus address, write
  localparam logic [7:0] DEV_R = 8'hb1;
  localparam int         HC    = 16;    // short hour so the timer moves
  typedef struct {logic [7:0] cmd; int n; logic [55:0] exp;} row_t;
  logic                    mclk_i;
  logic                    rst_n_i;
  logic                    fault_alert_i;
  logic                    fault_clear_o;
  logic [7:0]              bus_ownership_status_o;
  pmbus_sel_pkg::bus_req_t bus_i [2];
  pmbus_sel_pkg::bus_rsp_t bus_o [2];
  logic [7:0]              v [$];
  logic [7:0]              w [$];
  row_t                    rows [3];
  int                      n_fail;
  int                      samples_checked;
  int                      n_clr;
  int                      n_str;
  int                      cyc;
  int                      c0;
  logic [23:0]             h;

  dual_master_pmbus_control_selector #(.HOUR_CYCLES(HC)) u_dual_master_pmbus_control_selector (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .bus_o(bus_o),
    .vin_i(16'h1234), .pin_i(16'hbeef), .fw_rev_i(48'h665544332211),
    .fault_alert_i(fault_alert_i), .fault_clear_o(fault_clear_o),
    .bus_ownership_status_o(bus_ownership_status_o));

  host_pair_model u_host_pair_model (.mclk_i(mclk_i), .req_o(bus_i), .rsp_i(bus_o));

  // 20 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // cycles since reset release and count of status-clear pulses
  always @(posedge mclk_i) begin
    cyc <= rst_n_i ? cyc + 1 : 0;
    if (fault_clear_o === 1'b1) n_clr <= n_clr + 1;
    // stretched cycles on bus 0, one expected per fetched byte
    if (bus_o[0].stretch === 1'b1) n_str <= n_str + 1;
  end

  task automatic check(input logic [55:0] got, input logic [55:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // write transfer: pm 0 no check byte, 1 good, 2 corrupted
  task automatic send(input int b, input logic [7:0] cmd, input int cnt,
                      input logic [7:0] base, input int pm);
    u_host_pair_model.put(b, pmbus_sel_pkg::BYTE_ADDR, DEV_W);
    u_host_pair_model.put(b, pmbus_sel_pkg::BYTE_CMD, cmd);
    if (cnt > 0) u_host_pair_model.put(b, pmbus_sel_pkg::BYTE_DATA, cnt[7:0]);
    for (int i = 0; i < cnt; i++) u_host_pair_model.put(b, pmbus_sel_pkg::BYTE_DATA, base + i[7:0]);
    if (pm > 0) u_host_pair_model.put(b, pmbus_sel_pkg::BYTE_DATA,
                                      u_host_pair_model.crc[b] ^ (pm == 2 ? 8'h5a : 8'h00));
    u_host_pair_model.fin(b);
    repeat (4) @(posedge mclk_i);
    #1;
  endtask : send

  // read transfer; count is bounded so a bad count cannot run away
  task automatic rd(input int b, input logic [7:0] cmd, output logic [7:0] q [$]);
    logic [7:0] d;
    logic [7:0] e;
    int         n;
    q = {};
    u_host_pair_model.put(b, pmbus_sel_pkg::BYTE_ADDR, DEV_W);
    u_host_pair_model.put(b, pmbus_sel_pkg::BYTE_CMD, cmd);
    u_host_pair_model.put(b, pmbus_sel_pkg::BYTE_ADDR, DEV_R);
    u_host_pair_model.get(b, d);
    q.push_back(d);
    n = (cmd == pmbus_sel_pkg::CMD_BUS_STATUS) ? 0 : ((d > 8'd32) ? 32 : int'(d));
    for (int i = 0; i < n; i++) begin
      u_host_pair_model.get(b, d);
      q.push_back(d);
    end
    e = u_host_pair_model.crc[b];
    u_host_pair_model.get(b, d);
    check(d, e);
    u_host_pair_model.fin(b);
  endtask : rd

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  // hang guard
  initial begin
    repeat (100000) @(posedge mclk_i);
    n_fail++;
    print_verdict();
  end

  initial begin
    rst_n_i = 1'b0;
    fault_alert_i = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    n_clr = 0;
    n_str = 0;
    cyc = 0;
    rows[0] = '{pmbus_sel_pkg::CMD_READ_INPUT, 5, {16'h0, 16'hbeef, 16'h1234, 8'h04}};
    rows[1] = '{pmbus_sel_pkg::CMD_FW_REV, 7, {48'h665544332211, 8'h06}};
    rows[2] = '{pmbus_sel_pkg::CMD_BUS_STATUS, 1, 56'h01};
    repeat (6) @(posedge mclk_i);
    #1;
    rst_n_i = 1'b1;
    check(bus_ownership_status_o, 8'h01);
    check({bus_o[1].alert, bus_o[0].alert, fault_clear_o}, 3'b000);
    $display("test reset done");
    // owner reads: count, payload lsb first, then check byte
    foreach (rows[r]) begin
      rd(0, rows[r].cmd, v);
      for (int i = 0; i < rows[r].n; i++) check(v[i], rows[r].exp[8*i +: 8]);
    end
    $display("test read table done");
    send(1, pmbus_sel_pkg::CMD_READ_INPUT, 0, 8'h00, 0);
    check(bus_ownership_status_o[7], 1'b1);
    send(1, pmbus_sel_pkg::CMD_TAKE_OVER, 0, 8'h00, 2);
    check(bus_ownership_status_o[4], 1'b0);
    send(1, pmbus_sel_pkg::CMD_TAKE_OVER, 0, 8'h00, 1);
    check({bus_ownership_status_o[4], bus_ownership_status_o[0]}, 2'b10);
    check({bus_o[1].alert, bus_o[0].alert}, 2'b11);
    send(1, pmbus_sel_pkg::CMD_CLEAR_FAULTS, 0, 8'h00, 0);
    check({bus_o[1].alert, bus_o[0].alert, n_clr[1:0]}, 4'b0101);
    send(0, pmbus_sel_pkg::CMD_CLEAR_FAULTS, 0, 8'h00, 1);
    check({bus_o[1].alert, bus_o[0].alert, n_clr[1:0]}, 4'b0001);
    @(posedge mclk_i);
    #1 fault_alert_i = 1'b1;
    @(posedge mclk_i);
    #1 fault_alert_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
    check({bus_o[1].alert, bus_o[0].alert}, 2'b11);
    send(0, pmbus_sel_pkg::CMD_CLEAR_FAULTS, 0, 8'h00, 0);
    send(1, pmbus_sel_pkg::CMD_CLEAR_FAULTS, 0, 8'h00, 0);
    check(n_clr, 2);
    $display("test control handover done");
    // both storage halves written then read back
    for (int k = 0; k < 2; k++) begin
      send(1, k ? pmbus_sel_pkg::CMD_NVM_HIGH : pmbus_sel_pkg::CMD_NVM_LOW, 32, 8'h40 << k, 0);
    end
    for (int k = 0; k < 2; k++) begin
      rd(1, k ? pmbus_sel_pkg::CMD_NVM_HIGH : pmbus_sel_pkg::CMD_NVM_LOW, v);
      for (int i = 0; i < 33; i++) check(v[i], i == 0 ? 8'h20 : (8'h40 << k) + i - 1);
    end
    $display("test storage done");
    fork
      rd(1, pmbus_sel_pkg::CMD_FW_REV, v);
      rd(0, pmbus_sel_pkg::CMD_BUS_STATUS, w);
    join
    check({v[0], v[3]}, 16'h0633);
    check(w[0] & 8'h11, 8'h10);
    $display("test concurrent reads done");
    c0 = cyc;
    rd(1, pmbus_sel_pkg::CMD_RUN_TIMER, v);
    h = {v[3], v[2], v[1]};
    check({v[0], 7'h0, (h == c0 / HC) || (h == c0 / HC + 1)}, 16'h0301);
    $display("test run timer done");
    // mid-run reset: control back to bus 0, storage kept, one stretch per fetched byte
    @(posedge mclk_i);
    #1 rst_n_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    #1 rst_n_i = 1'b1;
    check(bus_ownership_status_o, 8'h01);
    c0 = n_str;
    rd(0, pmbus_sel_pkg::CMD_READ_INPUT, v);
    check(v[0], 8'h04);
    check(n_str - c0, pmbus_sel_pkg::INPUT_COUNT + 2);
    rd(0, pmbus_sel_pkg::CMD_NVM_HIGH, w);
    check(w[32], 8'h9f);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule : test_dual_master_pmbus_control_selector
